// >>> verilog/gtoc_map.vh
`ifndef GTOC_MAP_VH
`define GTOC_MAP_VH

// Register word addresses (byte address = index * 4)
`define GTOC_ADR_COUNT      4'h0
`define GTOC_ADR_TMR_CTRL   4'h1
`define GTOC_ADR_GATE_CTRL  4'h2
`define GTOC_ADR_FLAGS      4'h3
`define GTOC_ADR_ENABLES    4'h4
`define GTOC_ADR_OSC_CTRL   4'h5
`define GTOC_ADR_OSC_CTRL2  4'h6
`define GTOC_ADR_CCP_MODE   4'h7
`define GTOC_ADR_PERIOD     4'h8

// Timer control fields
`define GTOC_TC_ON          0
`define GTOC_TC_SECONDARY_OSCILLATOR_SEL    3

// Gate control fields
`define GTOC_GC_GE          7
`define GTOC_GC_POL         6
`define GTOC_GC_VAL         2
`define GTOC_GC_SS_HI       1
`define GTOC_GC_SS_LO       0

// Gate source codes
`define GTOC_GSS_PIN        2'h0
`define GTOC_GSS_PERIOD     2'h1
`define GTOC_GSS_CMP1       2'h2
`define GTOC_GSS_CMP2       2'h3

// Oscillator control fields
`define GTOC_OC_IDLE_ON_SLEEP_ENABLE       7
`define GTOC_OC_SCS_HI      1
`define GTOC_OC_SCS_LO      0
`define GTOC_SCS_SECONDARY  2'h1
`define GTOC_OC2_RUNFLAG    6
`define GTOC_OC2_WARMUP     3

// Compare mode for special event trigger
`define GTOC_CCP_SPECIAL    4'hB

// Flags / enables bit
`define GTOC_FL_OVF         0

// Reset values and count maximum
`define GTOC_RST_BYTE       8'h00
`define GTOC_RST_PERIOD     8'hFF
`define GTOC_COUNT_MAX      16'hFFFF

// Power modes
`define GTOC_PM_RUN         2'h0
`define GTOC_PM_SECONDARY_RUN_MODE     2'h1
`define GTOC_PM_SECONDARY_IDLE_MODE    2'h2
`define GTOC_PM_SLEEP       2'h3

`endif

// >>> verilog/gtoc_sync.v
`timescale 1ns/1ps
// Two-flop level synchroniser
module gtoc_sync
(
  input  wire clock_i,
  input  wire rst_n_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_q;
  reg sync_q;

  // First stage feeds only the second stage
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // gtoc_sync

// >>> verilog/gtoc_period_timer.v
`timescale 1ns/1ps
`include "gtoc_map.vh"
// 8-bit period timer, one-cycle pulse when it resets to zero after match
module gtoc_period_timer
(
  input  wire       clock_i,
  input  wire       rst_n_i,
  input  wire       enable_i,
  input  wire [7:0] limit_i,
  output reg        match_pulse_o
);
  reg [7:0] period_timer_count_q;

  // Match is checked on each enabled cycle; the reset to zero comes on the same edge as the pulse
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      period_timer_count_q <= `GTOC_RST_BYTE;
      match_pulse_o        <= 1'b0;
    end
    else if (enable_i && period_timer_count_q == limit_i)
    begin
      period_timer_count_q <= `GTOC_RST_BYTE;
      match_pulse_o        <= 1'b1;   // see RULE19
    end
    else
    begin
      period_timer_count_q <= enable_i ? period_timer_count_q + 8'h01
                                       : period_timer_count_q;
      match_pulse_o        <= 1'b0;
    end
  end
endmodule // gtoc_period_timer

// >>> verilog/gtoc_top.v
// Functional notes
// RULE1 - Any requester keeps secondary oscillator running
// RULE2 - Warm-up bit starts oscillator before consumers
// RULE3 - Software waits for oscillator start-up itself
// RULE4 - Oscillator keeps running in power-managed modes
// RULE5 - Clock select 01 enters secondary run
// RULE6 - Sleep with idle enable clear: secondary idle
// RULE7 - Status flag shows secondary clock active
// RULE8 - Count wraps FFFF to 0000, sets flag
// RULE9 - Overflow interrupt only when enable set
// RULE10 - Special trigger mode 1011 resets count
// RULE11 - Second unit trigger starts enabled A/D
// RULE12 - Trigger reset needs synchronous operation; the count is reset on any trigger, with no synchronous-mode check
// RULE13 - Software write beats trigger reset
// RULE14 - Trigger reset never sets overflow flag
// RULE15 - Gate enable counts when gate equals polarity
// RULE16 - Inactive gate holds count
// RULE17 - Gate select 00 pin, 01 period, 10 cmp1
// RULE18 - Gate select 11 routes comparator 2
// RULE19 - Period match gives one-cycle high pulse
// RULE20 - Gate synchronised by two flops first
// RULE21 - Overflow flag sticky, wrap beats clear
`timescale 1ns/1ps
`include "gtoc_map.vh"
module gtoc_top
(
  input  wire        clock_i,
  input  wire        rst_n_i,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Timer clock tick and external sources
  input  wire        timer_tick_i,
  input  wire        external_gate_pin_i,
  input  wire        comparator1_out_i,
  input  wire        comparator2_out_i,
  input  wire        compare1_trigger_i,
  input  wire        second_unit_trigger_i,
  input  wire        second_unit_uses_timer_i,
  input  wire        adc_enabled_i,
  input  wire        other_odd_timer_osc_req_i,
  input  wire        calendar_osc_select_i,
  input  wire        sleep_exec_i,
  input  wire        wake_i,
  input  wire        clock_monitor_fail_i,
  // Results
  output reg         timer_irq_o,
  output reg         adc_start_o,
  output reg         secondary_osc_enable_o,
  output reg  [1:0]  power_mode_o,
  output reg  [15:0] gated_timer_count_o
);
  // Reset released through two flops
  reg rst_m_q;
  reg rst_q;
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_m_q <= 1'b0;
      rst_q   <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_q   <= rst_m_q;
    end
  end
  wire rst_n = rst_q;

  // Software-visible state
  reg [15:0] count_q;
  reg [7:0]  tmr_ctrl_q;
  reg [7:0]  gate_ctrl_q;
  reg [7:0]  osc_ctrl_q;
  reg [7:0]  osc_ctrl2_q;
  reg [3:0]  ccp_mode1_q;
  reg [3:0]  ccp_mode2_q;
  reg [7:0]  period_limit_q;
  reg        period_on_q;
  reg        ovf_flag_q;
  reg        ovf_en_q;
  reg        failover_q;
  reg [1:0]  pm_q;

  // Bus decode: single-cycle ack, drops the cycle after
  wire       req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [3:0] widx  = wb_adr_i[5:2];
  wire       wr    = req & wb_we_i & wb_sel_i[0];
  wire [7:0] wbyte = wb_dat_i[7:0];
  wire       wr_count = req & wb_we_i & (widx == `GTOC_ADR_COUNT);

  // Gate source mux and synchroniser
  wire period_pulse;
  gtoc_period_timer u_period
  (
    .clock_i       (clock_i),
    .rst_n_i       (rst_n),
    .enable_i      (period_on_q),
    .limit_i       (period_limit_q),
    .match_pulse_o (period_pulse)
  );

  reg gate_raw;
  always @*
  begin
    case (gate_ctrl_q[`GTOC_GC_SS_HI:`GTOC_GC_SS_LO])   // see RULE17
      `GTOC_GSS_PIN:    gate_raw = external_gate_pin_i;
      `GTOC_GSS_PERIOD: gate_raw = period_pulse;
      `GTOC_GSS_CMP1:   gate_raw = comparator1_out_i;
      `GTOC_GSS_CMP2:   gate_raw = comparator2_out_i;  // see RULE18
      default:          gate_raw = 1'b0;
    endcase
  end

  wire gate_sync;
  gtoc_sync u_gate_sync
  (
    .clock_i (clock_i),
    .rst_n_i (rst_n),
    .d_i     (gate_raw),
    .q_o     (gate_sync)                              // see RULE20
  );

  // Gate is active when the synchronised level matches polarity
  wire gate_active = (gate_sync == gate_ctrl_q[`GTOC_GC_POL]); // see RULE15
  wire count_en = tmr_ctrl_q[`GTOC_TC_ON] & timer_tick_i &
                  (~gate_ctrl_q[`GTOC_GC_GE] | gate_active); // see RULE16

  // Special event trigger only from units in mode 1011
  wire trig1 = compare1_trigger_i & (ccp_mode1_q == `GTOC_CCP_SPECIAL);
  wire trig2 = second_unit_trigger_i & second_unit_uses_timer_i &
               (ccp_mode2_q == `GTOC_CCP_SPECIAL);
  wire trig  = trig1 | trig2;                          // see RULE10
  wire wrap  = count_en & (count_q == `GTOC_COUNT_MAX);

  // Counter: write first, then trigger, then increment
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      count_q <= 16'h0000;
    else if (wr_count)                                 // see RULE13
    begin
      if (wb_sel_i[0])
        count_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        count_q[15:8] <= wb_dat_i[15:8];
    end
    else if (trig)                                     // see RULE12
      count_q <= 16'h0000;                             // see RULE14
    else if (count_en)
      count_q <= count_q + 16'h0001;                   // see RULE8
  end

  // Overflow flag: set wins over a same-cycle clear
  wire ovf_clr = wr & (widx == `GTOC_ADR_FLAGS) & ~wbyte[`GTOC_FL_OVF];
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      ovf_flag_q <= 1'b0;
    else if (wrap & ~wr_count & ~trig)                 // see RULE8
      ovf_flag_q <= 1'b1;                              // see RULE21
    else if (ovf_clr)
      ovf_flag_q <= 1'b0;
  end

  // Control registers
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmr_ctrl_q     <= `GTOC_RST_BYTE;
      gate_ctrl_q    <= `GTOC_RST_BYTE;
      osc_ctrl_q     <= `GTOC_RST_BYTE;
      osc_ctrl2_q    <= `GTOC_RST_BYTE;
      ccp_mode1_q    <= 4'h0;
      ccp_mode2_q    <= 4'h0;
      period_limit_q <= `GTOC_RST_PERIOD;
      period_on_q    <= 1'b0;
      ovf_en_q       <= 1'b0;
    end
    else if (wr)
    begin
      case (widx)
        `GTOC_ADR_TMR_CTRL:  tmr_ctrl_q  <= wbyte;
        `GTOC_ADR_GATE_CTRL: gate_ctrl_q <= wbyte;
        `GTOC_ADR_ENABLES:   ovf_en_q    <= wbyte[`GTOC_FL_OVF]; // see RULE9
        `GTOC_ADR_OSC_CTRL:  osc_ctrl_q  <= wbyte;
        `GTOC_ADR_OSC_CTRL2: osc_ctrl2_q <= wbyte;
        `GTOC_ADR_CCP_MODE:
        begin
          ccp_mode1_q <= wbyte[3:0];
          ccp_mode2_q <= wbyte[7:4];
        end
        `GTOC_ADR_PERIOD:
        begin
          period_limit_q <= wbyte;
          period_on_q    <= wb_dat_i[8];
        end
        default: period_on_q <= period_on_q;
      endcase
    end
  end

  // Power mode sequencing for the secondary clock
  wire scs_sec = (osc_ctrl_q[`GTOC_OC_SCS_HI:`GTOC_OC_SCS_LO] ==
                  `GTOC_SCS_SECONDARY);
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      pm_q <= `GTOC_PM_RUN;
    else
    begin
      case (pm_q)
        `GTOC_PM_RUN:
          if (scs_sec & ~failover_q)
            pm_q <= `GTOC_PM_SECONDARY_RUN_MODE;                  // see RULE5
        `GTOC_PM_SECONDARY_RUN_MODE:
          if (failover_q | ~scs_sec)
            pm_q <= `GTOC_PM_RUN;
          else if (sleep_exec_i & ~osc_ctrl_q[`GTOC_OC_IDLE_ON_SLEEP_ENABLE])
            pm_q <= `GTOC_PM_SECONDARY_IDLE_MODE;                 // see RULE6
        `GTOC_PM_SECONDARY_IDLE_MODE:
          if (wake_i)
            pm_q <= `GTOC_PM_SECONDARY_RUN_MODE;
        default:
          pm_q <= `GTOC_PM_RUN;
      endcase
    end
  end

  // Clock monitor failover latches until clock select is rewritten
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
      failover_q <= 1'b0;
    else if (clock_monitor_fail_i & (pm_q != `GTOC_PM_RUN))
      failover_q <= 1'b1;
    else if (wr & (widx == `GTOC_ADR_OSC_CTRL))
      failover_q <= 1'b0;
  end

  // Oscillator request; not gated by any power mode
  wire osc_req = tmr_ctrl_q[`GTOC_TC_SECONDARY_OSCILLATOR_SEL] | other_odd_timer_osc_req_i |
                 calendar_osc_select_i | scs_sec |
                 osc_ctrl2_q[`GTOC_OC2_WARMUP];        // see RULE1
  wire sec_active = (pm_q == `GTOC_PM_SECONDARY_RUN_MODE) |
                    (pm_q == `GTOC_PM_SECONDARY_IDLE_MODE);

  // Read mux
  reg [31:0] rdata;
  always @*
  begin
    rdata = 32'h0000_0000;
    case (widx)
      `GTOC_ADR_COUNT:     rdata[15:0] = count_q;
      `GTOC_ADR_TMR_CTRL:  rdata[7:0]  = tmr_ctrl_q;
      `GTOC_ADR_GATE_CTRL:
      begin
        rdata[7:0] = gate_ctrl_q;
        rdata[`GTOC_GC_VAL] = gate_active;
      end
      `GTOC_ADR_FLAGS:     rdata[`GTOC_FL_OVF] = ovf_flag_q;
      `GTOC_ADR_ENABLES:   rdata[`GTOC_FL_OVF] = ovf_en_q;
      `GTOC_ADR_OSC_CTRL:  rdata[7:0] = osc_ctrl_q;
      `GTOC_ADR_OSC_CTRL2:
      begin
        rdata[7:0] = osc_ctrl2_q;
        rdata[`GTOC_OC2_RUNFLAG] = sec_active;         // see RULE7
      end
      `GTOC_ADR_CCP_MODE:  rdata[7:0] = {ccp_mode2_q, ccp_mode1_q};
      `GTOC_ADR_PERIOD:    rdata[8:0] = {period_on_q, period_limit_q};
      default:             rdata = 32'h0000_0000;
    endcase
  end

  // Registered outputs
  always @(posedge clock_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o               <= 1'b0;
      wb_dat_o               <= 32'h0000_0000;
      timer_irq_o            <= 1'b0;
      adc_start_o            <= 1'b0;
      secondary_osc_enable_o <= 1'b0;
      power_mode_o           <= `GTOC_PM_RUN;
      gated_timer_count_o    <= 16'h0000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdata : 32'h0000_0000;
      timer_irq_o <= ovf_flag_q & ovf_en_q;            // see RULE9
      adc_start_o <= trig2 & adc_enabled_i;            // see RULE11
      // Held while a secondary mode lasts, so it never drops first; RULE2 RULE4
      secondary_osc_enable_o <= osc_req | sec_active;  // see RULE4
      power_mode_o <= pm_q;
      gated_timer_count_o <= count_q;
    end
  end
endmodule // gtoc_top

// >>> test/gtoc_top_sva.sv
`timescale 1ns/1ps
`include "gtoc_map.vh"
// Port-level watcher; count output lags its cause by two edges
module gtoc_top_sva
(
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire        timer_tick_i,
  input wire        compare1_trigger_i,
  input wire        second_unit_trigger_i,
  input wire        adc_enabled_i,
  input wire        other_odd_timer_osc_req_i,
  input wire        calendar_osc_select_i,
  input wire        adc_start_o,
  input wire        secondary_osc_enable_o,
  input wire [1:0]  power_mode_o,
  input wire [15:0] gated_timer_count_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Bus handshake
  AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // Count moves only by one step unless written or cleared
  AST_CNT_STEP: assert property (
    $changed(gated_timer_count_o) && !$past(wb_cyc_i, 2)
    && !$past(compare1_trigger_i, 2) && !$past(second_unit_trigger_i, 2)
    |-> gated_timer_count_o == $past(gated_timer_count_o) + 16'h1)
    else $error("count jumped");
  AST_CNT_HOLD: assert property (
    !$past(timer_tick_i, 2) && !$past(wb_cyc_i, 2)
    && !$past(compare1_trigger_i, 2) && !$past(second_unit_trigger_i, 2)
    |-> $stable(gated_timer_count_o)) else $error("count moved idle");
  AST_TRIG_CLR: assert property (
    $past(compare1_trigger_i, 2) && !$past(wb_cyc_i, 2)
    |-> gated_timer_count_o == 16'h0) else $error("trigger kept count");
  AST_ADC_GO: assert property (
    second_unit_trigger_i && adc_enabled_i |=> adc_start_o)
    else $error("conversion not started");
  AST_ADC_ONLY: assert property (
    adc_start_o |-> $past(second_unit_trigger_i && adc_enabled_i))
    else $error("conversion without cause");
  AST_OSC_REQ: assert property (
    other_odd_timer_osc_req_i || calendar_osc_select_i
    |=> secondary_osc_enable_o) else $error("oscillator not running");
  AST_MODE_OSC: assert property (
    power_mode_o inside {`GTOC_PM_SECONDARY_RUN_MODE, `GTOC_PM_SECONDARY_IDLE_MODE}
    && $stable(power_mode_o) |-> secondary_osc_enable_o)
    else $error("oscillator off in secondary mode");
endmodule // gtoc_top_sva

bind gtoc_top gtoc_top_sva u_sva (.clock_i, .rst_n_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_dat_o, .timer_tick_i, .compare1_trigger_i,
  .second_unit_trigger_i, .adc_enabled_i, .other_odd_timer_osc_req_i,
  .calendar_osc_select_i, .adc_start_o, .secondary_osc_enable_o,
  .power_mode_o, .gated_timer_count_o);

// >>> test/tb_gtoc_top.sv
`timescale 1ns/1ps
`include "gtoc_map.vh"
module tb_gtoc_top;
  logic        clock_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, timer_tick_i;
  logic        external_gate_pin_i, comparator1_out_i, comparator2_out_i;
  logic        compare1_trigger_i, second_unit_trigger_i, adc_enabled_i;
  logic        second_unit_uses_timer_i, other_odd_timer_osc_req_i;
  logic        calendar_osc_select_i, sleep_exec_i, wake_i;
  logic        clock_monitor_fail_i, wb_ack_o, timer_irq_o, adc_start_o;
  logic        secondary_osc_enable_o;
  logic [1:0]  power_mode_o;
  logic [3:0]  wb_sel_i;
  logic [5:0]  wb_adr_i;
  logic [15:0] gated_timer_count_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd, c0;
  int          failures, tests_run, i, p, s, v;

  gtoc_top dut (.*);

  // 10 MHz clock
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic print_verdict;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Reset read: gate value bit is set, low pin meets low polarity
  function automatic logic [31:0] reset_val(input int k);
    case (k)
      2:       reset_val = 32'h4;
      8:       reset_val = 32'hFF;
      default: reset_val = 32'h0;
    endcase
  endfunction

  // Gated count moves only while the gate level equals the polarity
  function automatic logic exp_move(input logic g, input logic pol);
    exp_move = (g == pol);
  endfunction

  // One classic cycle; t raises the unit-one trigger at the taking edge
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [31:0] d, input logic t);
    int n;
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {a, 2'h0};
    wb_dat_i <= d;
    compare1_trigger_i <= t;
    n = 0;
    do
    begin
      @(posedge clock_i);
      compare1_trigger_i <= 1'b0;
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      failures++;
      print_verdict;
    end
  endtask

  // Raise or drop one oscillator requester
  task automatic req(input int k, input logic b);
    case (k)
      0: other_odd_timer_osc_req_i <= b;
      1: calendar_osc_select_i <= b;
      2: wb(4'h1, 1'h1, {28'h0, b, 3'h0}, 1'h0);
      3: wb(4'h6, 1'h1, {28'h0, b, 3'h0}, 1'h0);
      default: wb(4'h5, 1'h1, {31'h0, b}, 1'h0);
    endcase
  endtask

  initial
  begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, timer_tick_i, wb_adr_i} = '0;
    {external_gate_pin_i, comparator1_out_i, comparator2_out_i} = '0;
    {compare1_trigger_i, second_unit_trigger_i, adc_enabled_i} = '0;
    {other_odd_timer_osc_req_i, calendar_osc_select_i, sleep_exec_i} = '0;
    {wake_i, clock_monitor_fail_i, wb_dat_i} = '0;
    second_unit_uses_timer_i = 1'b1;
    wb_sel_i = 4'hF;
    failures = 0;
    tests_run = 0;
    void'($urandom(64));
    idle(20);
    rst_n_i <= 1'b1;
    idle(3);
    // Reset values, index 9 is unmapped
    for (i = 0; i < 10; i++)
    begin
      wb(i[3:0], 1'h0, 32'h0, 1'h0);
      chk(rd, reset_val(i));
    end
    // Wrap from FFFE with the interrupt masked, then unmasked
    wb(4'h0, 1'h1, 32'hFFFE, 1'h0);
    wb(4'h1, 1'h1, 32'h1, 1'h0);
    timer_tick_i <= 1'b1;
    idle(3);
    timer_tick_i <= 1'b0;
    wb(4'h0, 1'h0, 32'h0, 1'h0);
    chk(rd, 32'h1);
    wb(4'h3, 1'h0, 32'h0, 1'h0);
    chk(rd, 32'h1);
    chk(timer_irq_o, 1'h0);
    wb(4'h4, 1'h1, 32'h1, 1'h0);
    idle(2);
    chk(timer_irq_o, 1'h1);
    wb(4'h3, 1'h1, 32'h0, 1'h0);
    idle(2);
    chk(timer_irq_o, 1'h0);
    // Wrap on the very edge that takes a flag clear: the flag survives
    wb(4'h0, 1'h1, 32'hFFFE, 1'h0);
    timer_tick_i <= 1'b1;
    wb(4'h3, 1'h1, 32'h0, 1'h0);
    timer_tick_i <= 1'b0;
    wb(4'h3, 1'h0, 32'h0, 1'h0);
    chk(rd, 32'h1);
    wb(4'h3, 1'h1, 32'h0, 1'h0);
    // Unit-one trigger clears without flagging; a same-cycle write wins
    wb(4'h7, 1'h1, 32'hBB, 1'h0);
    v = $urandom | 1;
    wb(4'h0, 1'h1, 32'hFFFF, 1'h0);
    // Trigger on a wrapping tick of the running timer: clear, no flag
    compare1_trigger_i <= 1'b1;
    timer_tick_i <= 1'b1;
    @(posedge clock_i) {compare1_trigger_i, timer_tick_i} <= 2'b00;
    wb(4'h0, 1'h0, 32'h0, 1'h0);
    chk(rd, 32'h0);
    wb(4'h3, 1'h0, 32'h0, 1'h0);
    chk(rd, 32'h0);
    wb(4'h0, 1'h1, {16'h0, v[15:0]}, 1'h1);
    wb(4'h0, 1'h0, 32'h0, 1'h0);
    chk(rd, {16'h0, v[15:0]});
    // Conversion start needs the converter enabled
    for (i = 0; i < 2; i++)
    begin
      adc_enabled_i <= i[0];
      second_unit_trigger_i <= 1'b1;
      @(posedge clock_i) second_unit_trigger_i <= 1'b0;
      @(posedge clock_i) chk(adc_start_o, i[0]);
    end
    // Every source and polarity; unselected sources carry the opposite
    timer_tick_i <= 1'b1;
    for (p = 0; p < 2; p++)
      for (s = 0; s < 4; s++)
      begin
        v = (s == 1) ? 0 : $urandom % 2;
        wb(4'h2, 1'h1, 32'h80 | (p << 6) | s, 1'h0);
        external_gate_pin_i <= v[0] ^ (s != 0);
        comparator1_out_i <= v[0] ^ (s != 2);
        comparator2_out_i <= v[0] ^ (s != 3);
        idle(4);
        wb(4'h0, 1'h0, 32'h0, 1'h0);
        c0 = rd;
        wb(4'h0, 1'h0, 32'h0, 1'h0);
        chk(rd != c0, exp_move(v[0], p[0]));
      end
    // Period-match pulses, limit 3, let only a few counts through
    wb(4'h8, 1'h1, 32'h103, 1'h0);
    wb(4'h2, 1'h1, 32'hC1, 1'h0);
    wb(4'h0, 1'h0, 32'h0, 1'h0);
    c0 = rd;
    idle(40);
    wb(4'h0, 1'h0, 32'h0, 1'h0);
    c0 = {16'h0, rd[15:0] - c0[15:0]};
    chk(c0 > 0 && c0 < 20, 1'h1);
    timer_tick_i <= 1'b0;
    // Each requester alone runs the oscillator
    for (i = 0; i < 5; i++)
    begin
      req(i, 1'b1);
      idle(3);
      chk(secondary_osc_enable_o, 1'h1);
      req(i, 1'b0);
      idle(3);
      chk(secondary_osc_enable_o, 1'h0);
    end
    // Secondary run, idle on sleep, wake, then failover
    wb(4'h5, 1'h1, 32'h1, 1'h0);
    idle(3);
    chk(power_mode_o, `GTOC_PM_SECONDARY_RUN_MODE);
    wb(4'h6, 1'h0, 32'h0, 1'h0);
    chk(rd, 32'h40);
    sleep_exec_i <= 1'b1;
    @(posedge clock_i) sleep_exec_i <= 1'b0;
    idle(3);
    chk(power_mode_o, `GTOC_PM_SECONDARY_IDLE_MODE);
    chk(secondary_osc_enable_o, 1'h1);
    wake_i <= 1'b1;
    @(posedge clock_i) wake_i <= 1'b0;
    idle(3);
    chk(power_mode_o, `GTOC_PM_SECONDARY_RUN_MODE);
    clock_monitor_fail_i <= 1'b1;
    @(posedge clock_i) clock_monitor_fail_i <= 1'b0;
    idle(3);
    wb(4'h6, 1'h0, 32'h0, 1'h0);
    chk(rd, 32'h0);
    print_verdict;
  end
endmodule // tb_gtoc_top
